/* logic/accel_defines.svh */
// Register offsets, field positions and reset values of the register bank
`ifndef ACCEL_DEFINES_SVH
`define ACCEL_DEFINES_SVH

`define ACCEL_ADDR_STATUS      8'h00
`define ACCEL_ADDR_X_HI        8'h01
`define ACCEL_ADDR_X_LO        8'h02
`define ACCEL_ADDR_Y_HI        8'h03
`define ACCEL_ADDR_Y_LO        8'h04
`define ACCEL_ADDR_Z_HI        8'h05
`define ACCEL_ADDR_Z_LO        8'h06
`define ACCEL_ADDR_LOWER_FIRST 8'h07
`define ACCEL_ADDR_LOWER_LAST  8'h20
`define ACCEL_ADDR_PLS_SETUP   8'h21
`define ACCEL_ADDR_PLS_EVENT   8'h22
`define ACCEL_ADDR_PULSE_THS_X 8'h23
`define ACCEL_ADDR_PULSE_THS_Y 8'h24
`define ACCEL_ADDR_PULSE_THS_Z 8'h25
`define ACCEL_ADDR_PLS_TLIM    8'h26
`define ACCEL_ADDR_PULSE_LAT   8'h27
`define ACCEL_ADDR_PULSE_WIN   8'h28
`define ACCEL_ADDR_ASLP_CNT    8'h29
`define ACCEL_ADDR_CTRL_A      8'h2A
`define ACCEL_ADDR_CTRL_B      8'h2B
`define ACCEL_ADDR_CTRL_C      8'h2C
`define ACCEL_ADDR_CTRL_D      8'h2D
`define ACCEL_ADDR_CTRL_E      8'h2E
`define ACCEL_ADDR_TRIM_X      8'h2F
`define ACCEL_ADDR_TRIM_Y      8'h30
`define ACCEL_ADDR_TRIM_Z      8'h31
`define ACCEL_ADDR_RSVD_FIRST  8'h40
`define ACCEL_ADDR_RSVD_LAST   8'h7F
`define ACCEL_ADDR_WRAP_TGT    8'h0D

`define ACCEL_NUM_CFG          17
`define ACCEL_RST_VAL          8'h00

`define ACCEL_IDX_PLS_EVENT    1
`define ACCEL_IDX_THS_FIRST    2
`define ACCEL_IDX_THS_LAST     4
`define ACCEL_IDX_CTRL_A       9
`define ACCEL_IDX_CTRL_B       10

`define ACCEL_BIT_ACTIVE       0
`define ACCEL_BIT_FAST_READ    1
`define ACCEL_BIT_SW_RST       6

`endif

/* logic/accel_pkg.sv */
// Types shared by the register bank modules
package accel_pkg;

  typedef logic [7:0] accel_byte_t;

  typedef enum logic [1:0] {
    ACCEL_FMODE_OFF      = 2'b00,
    ACCEL_FMODE_CIRCULAR = 2'b01,
    ACCEL_FMODE_FILL     = 2'b10,
    ACCEL_FMODE_TRIGGER  = 2'b11
  } accel_fmode_t;

endpackage : accel_pkg

/* logic/accel_sample_hold.sv */
// Sample data byte selection with low-byte hold per axis
`include "accel_defines.svh"

module accel_sample_hold (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Read request
  input  wire logic                rd_stb,
  input  wire accel_pkg::accel_byte_t rd_addr,
  // Live samples
  input  wire logic [13:0]         x_sample,
  input  wire logic [13:0]         y_sample,
  input  wire logic [13:0]         z_sample,
  // Selected byte
  output      accel_pkg::accel_byte_t rdata
);
  import accel_pkg::*;

  logic [13:0] samples [0:2];
  accel_byte_t hi_byte [0:2];
  accel_byte_t lo_hold_r [0:2];
  logic [2:0]  hi_hit;
  logic [2:0]  lo_hit;

  assign samples[0] = x_sample;
  assign samples[1] = y_sample;
  assign samples[2] = z_sample;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_axis
      localparam accel_byte_t HI_ADDR = 8'(`ACCEL_ADDR_X_HI + 2 * i);
      localparam accel_byte_t LO_ADDR = 8'(`ACCEL_ADDR_X_LO + 2 * i);
      assign hi_byte[i] = samples[i][13:6];
      assign hi_hit[i]  = rd_addr == HI_ADDR;
      assign lo_hit[i]  = rd_addr == LO_ADDR;
      // Low six bits frozen when the high byte is read
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          lo_hold_r[i] <= `ACCEL_RST_VAL;
        end else if (rd_stb && hi_hit[i]) begin // see R13
          lo_hold_r[i] <= {samples[i][5:0], 2'b00};
        end
      end
    end
  endgenerate

  assign rdata = hi_hit[0] ? hi_byte[0] :
                 hi_hit[1] ? hi_byte[1] :
                 hi_hit[2] ? hi_byte[2] :
                 lo_hit[0] ? lo_hold_r[0] :
                 lo_hit[1] ? lo_hold_r[1] :
                 lo_hit[2] ? lo_hold_r[2] : `ACCEL_RST_VAL;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence x_hi_read_s;
    rd_stb && rd_addr == `ACCEL_ADDR_X_HI;
  endsequence

  sequence x_lo_read_s;
    rd_addr == `ACCEL_ADDR_X_LO;
  endsequence

  low_byte_pair_a: assert property ( // see R13
    x_hi_read_s ##1 x_lo_read_s |->
      rdata == {$past(x_sample[5:0]), 2'b00})
    else $error("low byte not from same sample as high byte");

endmodule : accel_sample_hold

/* logic/accel_regmap.sv */
// Upper register bank with read pointer, write protection and read mux
`include "accel_defines.svh"

// Summary of operation
// R1: Entering standby leaves every stored register unchanged.
// R2: Entering active clears the pulse event source register to default.
// R3: Pulse thresholds writable always; each write restarts its debounce count.
// R4: Config changes only in standby, except active bit and reset bit.
// R5: Pointer advances only on reads; a stop clears the stored pointer.
// R6: Each read steps to its next address; last trim wraps to 0x0D.
// R7: Reserved range 0x40 to 0x7F reads zero; host does not write it.
// R8: FIFO mode off: address 0x00 returns live sample status.
// R9: FIFO mode on: address 0x00 returns FIFO status.
// R10: Host fetches FIFO data starting at the X high byte.
// R11: Fast-read skips low data bytes; otherwise all six read in order.
// R12: After reset system control A is zero: 800 Hz rate, standby.
// R13: A low byte read right after its high byte is the same sample.
// R14: Protected writes outside standby are ignored, keeping old contents.
module accel_regmap (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // Host byte transactions
  input  wire logic                   addr_stb,
  input  wire accel_pkg::accel_byte_t addr_in,
  input  wire logic                   wr_stb,
  input  wire accel_pkg::accel_byte_t wr_data,
  input  wire logic                   rd_stb,
  input  wire logic                   stop_stb,
  output      logic                   rd_valid,
  output      accel_pkg::accel_byte_t rd_data,
  // Device status and samples
  input  wire accel_pkg::accel_fmode_t fifo_mode,
  input  wire accel_pkg::accel_byte_t sample_status,
  input  wire accel_pkg::accel_byte_t fifo_status,
  input  wire logic [13:0]            x_sample,
  input  wire logic [13:0]            y_sample,
  input  wire logic [13:0]            z_sample,
  input  wire logic                   pulse_event_source_load,
  input  wire accel_pkg::accel_byte_t pulse_event_source_in,
  // Lower register bank
  output      logic                   lower_rd_stb,
  output      accel_pkg::accel_byte_t lower_addr,
  input  wire accel_pkg::accel_byte_t lower_rdata,
  // Register contents
  output      accel_pkg::accel_byte_t pulse_config,
  output      accel_pkg::accel_byte_t pulse_event_source,
  output      accel_pkg::accel_byte_t pulse_threshold_x,
  output      accel_pkg::accel_byte_t pulse_threshold_y,
  output      accel_pkg::accel_byte_t pulse_threshold_z,
  output      accel_pkg::accel_byte_t pulse_time_limit,
  output      accel_pkg::accel_byte_t pulse_second_latency,
  output      accel_pkg::accel_byte_t pulse_second_window,
  output      accel_pkg::accel_byte_t auto_sleep_counter,
  output      accel_pkg::accel_byte_t system_control_a,
  output      accel_pkg::accel_byte_t system_control_b,
  output      accel_pkg::accel_byte_t wake_and_pin_polarity,
  output      accel_pkg::accel_byte_t interrupt_enables,
  output      accel_pkg::accel_byte_t interrupt_pin_routing,
  output      accel_pkg::accel_byte_t x_axis_trim,
  output      accel_pkg::accel_byte_t y_axis_trim,
  output      accel_pkg::accel_byte_t z_axis_trim,
  // Control strobes and levels
  output      logic                   device_active,
  output      logic                   sw_reset,
  output      logic [2:0]             dbnc_restart
);
  import accel_pkg::*;

  accel_byte_t cfg_r [0:`ACCEL_NUM_CFG-1];
  accel_byte_t cfg_nxt [0:`ACCEL_NUM_CFG-1];
  logic [`ACCEL_NUM_CFG-1:0] cfg_hit;
  accel_byte_t ptr_r;
  accel_byte_t ptr_nxt;
  accel_byte_t step_addr;
  accel_byte_t rd_data_r;
  accel_byte_t rd_mux;
  accel_byte_t cfg_rdata;
  accel_byte_t data_rdata;
  accel_byte_t status_rdata;
  logic [4:0]  cfg_idx;
  logic        rd_valid_r;
  logic        sw_rst_r;
  logic        act_d_r;
  logic [2:0]  dbnc_r;
  logic        active;
  logic        standby;
  logic        fast_read;
  logic        act_rise;
  logic        in_status;
  logic        in_data;
  logic        in_lower;
  logic        in_cfg;
  logic        sw_rst_req;

  assign active    = cfg_r[`ACCEL_IDX_CTRL_A][`ACCEL_BIT_ACTIVE];
  assign standby   = !active;
  assign fast_read = cfg_r[`ACCEL_IDX_CTRL_A][`ACCEL_BIT_FAST_READ];
  assign act_rise  = active && !act_d_r;

  // Address decode of the current pointer
  assign in_status = ptr_r == `ACCEL_ADDR_STATUS;
  assign in_data   = ptr_r >= `ACCEL_ADDR_X_HI && ptr_r <= `ACCEL_ADDR_Z_LO;
  assign in_lower  = ptr_r >= `ACCEL_ADDR_LOWER_FIRST &&
                     ptr_r <= `ACCEL_ADDR_LOWER_LAST;
  assign in_cfg    = ptr_r >= `ACCEL_ADDR_PLS_SETUP &&
                     ptr_r <= `ACCEL_ADDR_TRIM_Z;
  assign cfg_idx   = 5'(ptr_r - `ACCEL_ADDR_PLS_SETUP);

  // Writing the reset bit is honoured in any mode
  assign sw_rst_req = wr_stb && cfg_hit[`ACCEL_IDX_CTRL_B] &&
                      wr_data[`ACCEL_BIT_SW_RST]; // see R4

  genvar i;
  generate
    for (i = 0; i < `ACCEL_NUM_CFG; i++) begin : g_cfg
      localparam bit ANYTIME = i >= `ACCEL_IDX_THS_FIRST &&
                               i <= `ACCEL_IDX_THS_LAST;
      localparam bit RDONLY  = i == `ACCEL_IDX_PLS_EVENT;
      localparam bit IS_CA   = i == `ACCEL_IDX_CTRL_A;
      localparam bit IS_CB   = i == `ACCEL_IDX_CTRL_B;
      logic wr_full;
      logic wr_part;
      accel_byte_t part_val;

      assign cfg_hit[i] = in_cfg && cfg_idx == 5'(i);
      // Thresholds take writes in any mode, the rest only in standby
      assign wr_full = wr_stb && cfg_hit[i] && !RDONLY &&
                       (ANYTIME || standby); // see R3, R4
      // Active mode: only the exempt bit lands, the rest is kept
      assign wr_part = wr_stb && cfg_hit[i] && active &&
                       (IS_CA || IS_CB); // see R14
      assign part_val = IS_CA ?
        {cfg_r[i][7:1], wr_data[`ACCEL_BIT_ACTIVE]} :
        {cfg_r[i][7], wr_data[`ACCEL_BIT_SW_RST], cfg_r[i][5:0]};

      if (RDONLY) begin : g_src
        // New event wins over the clear on entering active
        assign cfg_nxt[i] = sw_rst_r       ? `ACCEL_RST_VAL :
                            pulse_event_source_load ? pulse_event_source_in :
                            act_rise       ? `ACCEL_RST_VAL : // see R2
                            cfg_r[i];
      end else begin : g_rw
        assign cfg_nxt[i] = sw_rst_r ? `ACCEL_RST_VAL :
                            wr_full  ? wr_data :
                            wr_part  ? part_val :
                            cfg_r[i]; // see R1
      end

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          cfg_r[i] <= `ACCEL_RST_VAL; // see R12
        end else begin
          cfg_r[i] <= cfg_nxt[i];
        end
      end
    end
  endgenerate

  // Next address of a burst read
  always_comb begin
    step_addr = 8'(ptr_r + 8'h01);
    if (ptr_r == `ACCEL_ADDR_TRIM_Z) begin
      step_addr = `ACCEL_ADDR_WRAP_TGT; // see R6
    end else if (fast_read && ptr_r == `ACCEL_ADDR_X_HI) begin
      step_addr = `ACCEL_ADDR_Y_HI; // see R11
    end else if (fast_read && ptr_r == `ACCEL_ADDR_Y_HI) begin
      step_addr = `ACCEL_ADDR_Z_HI; // see R11
    end else if (fast_read && ptr_r == `ACCEL_ADDR_Z_HI) begin
      step_addr = `ACCEL_ADDR_STATUS; // see R11
    end
  end

  // Stop clears, address phase loads, only reads advance
  assign ptr_nxt = stop_stb ? `ACCEL_ADDR_STATUS : // see R5
                   addr_stb ? addr_in :
                   rd_stb   ? step_addr : // see R5, R6
                   ptr_r;

  accel_sample_hold u_sample_hold (
    .clk      (clk),
    .rst_b    (rst_b),
    .rd_stb   (rd_stb),
    .rd_addr  (ptr_r),
    .x_sample (x_sample),
    .y_sample (y_sample),
    .z_sample (z_sample),
    .rdata    (data_rdata)
  );

  // Read data selection
  assign status_rdata = (fifo_mode == ACCEL_FMODE_OFF) ?
                        sample_status : fifo_status; // see R8, R9
  assign cfg_rdata    = cfg_r[cfg_idx];
  assign rd_mux = in_status ? status_rdata :
                  in_data   ? data_rdata : // see R10
                  in_lower  ? lower_rdata :
                  in_cfg    ? cfg_rdata :
                  `ACCEL_RST_VAL; // see R7

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_r      <= `ACCEL_ADDR_STATUS;
      rd_data_r  <= `ACCEL_RST_VAL;
      rd_valid_r <= 1'b0;
      sw_rst_r   <= 1'b0;
      act_d_r    <= 1'b0;
      dbnc_r     <= 3'b000;
    end else begin
      ptr_r      <= ptr_nxt;
      rd_data_r  <= rd_stb ? rd_mux : rd_data_r;
      rd_valid_r <= rd_stb;
      sw_rst_r   <= sw_rst_req;
      act_d_r    <= active;
      dbnc_r     <= {3{wr_stb}} & cfg_hit[`ACCEL_IDX_THS_LAST:
                                          `ACCEL_IDX_THS_FIRST]; // see R3
    end
  end

  assign rd_valid     = rd_valid_r;
  assign rd_data      = rd_data_r;
  assign lower_rd_stb = rd_stb && in_lower;
  assign lower_addr   = ptr_r;
  assign device_active = active;
  assign sw_reset     = sw_rst_r;
  assign dbnc_restart = dbnc_r;

  assign pulse_config          = cfg_r[0];
  assign pulse_event_source    = cfg_r[1];
  assign pulse_threshold_x     = cfg_r[2];
  assign pulse_threshold_y     = cfg_r[3];
  assign pulse_threshold_z     = cfg_r[4];
  assign pulse_time_limit      = cfg_r[5];
  assign pulse_second_latency  = cfg_r[6];
  assign pulse_second_window   = cfg_r[7];
  assign auto_sleep_counter    = cfg_r[8];
  assign system_control_a      = cfg_r[9];
  assign system_control_b      = cfg_r[10];
  assign wake_and_pin_polarity = cfg_r[11];
  assign interrupt_enables     = cfg_r[12];
  assign interrupt_pin_routing = cfg_r[13];
  assign x_axis_trim           = cfg_r[14];
  assign y_axis_trim           = cfg_r[15];
  assign z_axis_trim           = cfg_r[16];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic plain_read;
  assign plain_read = rd_stb && !stop_stb && !addr_stb;

  sequence to_standby_s;
    $fell(active) && !$past(sw_rst_r);
  endsequence

  keep_on_standby_a: assert property ( // see R1
    to_standby_s |-> cfg_r[0] == $past(cfg_r[0]) &&
                     cfg_r[14] == $past(cfg_r[14]))
    else $error("register changed on entering standby");

  src_clear_a: assert property ( // see R2
    act_rise && !pulse_event_source_load |=> cfg_r[1] == `ACCEL_RST_VAL)
    else $error("pulse source not cleared on entering active");

  ths_anytime_a: assert property ( // see R3
    wr_stb && active && ptr_r == `ACCEL_ADDR_PULSE_THS_Y && !sw_rst_r
    |=> cfg_r[3] == $past(wr_data) && dbnc_r == 3'b010)
    else $error("threshold write lost or no debounce restart");

  cfg_locked_a: assert property ( // see R4, R14
    wr_stb && active && ptr_r == `ACCEL_ADDR_PLS_SETUP && !sw_rst_r
    |=> $stable(cfg_r[0]))
    else $error("protected register written while active");

  ctrl_a_exempt_a: assert property ( // see R4
    wr_stb && active && ptr_r == `ACCEL_ADDR_CTRL_A && !sw_rst_r
    |=> cfg_r[9] == {$past(cfg_r[9][7:1]), $past(wr_data[0])})
    else $error("active bit write mishandled");

  stop_clear_a: assert property ( // see R5
    stop_stb |=> ptr_r == `ACCEL_ADDR_STATUS ##1
                 (ptr_r == `ACCEL_ADDR_STATUS || $past(addr_stb) ||
                  $past(rd_stb)))
    else $error("pointer not cleared by stop");

  trim_wrap_a: assert property ( // see R6
    plain_read && ptr_r == `ACCEL_ADDR_TRIM_Z
    |=> ptr_r == `ACCEL_ADDR_WRAP_TGT)
    else $error("last trim register did not wrap");

  rsvd_zero_a: assert property ( // see R7
    rd_stb && ptr_r >= `ACCEL_ADDR_RSVD_FIRST &&
    ptr_r <= `ACCEL_ADDR_RSVD_LAST |=> rd_valid && rd_data == 8'h00)
    else $error("reserved address read not zero");

  status_sel_a: assert property ( // see R8, R9
    rd_stb && in_status |=> rd_data == ($past(fifo_mode) == ACCEL_FMODE_OFF
                            ? $past(sample_status) : $past(fifo_status)))
    else $error("wrong status source at address zero");

  fast_skip_a: assert property ( // see R11
    plain_read && ptr_r == `ACCEL_ADDR_X_HI
    |=> ptr_r == ($past(fast_read) ? `ACCEL_ADDR_Y_HI : `ACCEL_ADDR_X_LO))
    else $error("data auto-increment step wrong");

  swrst_zero_a: assert property ( // see R12
    sw_rst_r |=> cfg_r[9] == `ACCEL_RST_VAL && cfg_r[10] == `ACCEL_RST_VAL)
    else $error("software reset left control registers set");

endmodule : accel_regmap

/* test/accel_host_bfm.sv */
// Host model issuing byte transactions to the register bank
module accel_host_bfm (
  // Clock
  input  wire logic                   clk,
  // Requests
  output      logic                   addr_stb,
  output      accel_pkg::accel_byte_t addr_in,
  output      logic                   wr_stb,
  output      accel_pkg::accel_byte_t wr_data,
  output      logic                   rd_stb,
  output      logic                   stop_stb,
  // Read answer
  input  wire logic                   rd_valid,
  input  wire accel_pkg::accel_byte_t rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import accel_pkg::*;

  initial begin
    {addr_stb, wr_stb, rd_stb, stop_stb} = 4'h0;
    addr_in = 8'h00;
    wr_data = 8'h00;
  end

  // Released buses show the inverse so stale data never looks valid
  task automatic set_ptr(input accel_byte_t a);
    @(posedge clk);
    addr_stb <= 1'b1;
    addr_in  <= a;
    @(posedge clk);
    addr_stb <= 1'b0;
    addr_in  <= ~a;
  endtask : set_ptr

  task automatic write_reg(input accel_byte_t a, input accel_byte_t d);
    if (a >= 8'h40 && a <= 8'h7f) return;
    set_ptr(a);
    @(posedge clk);
    wr_stb  <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_stb  <= 1'b0;
    wr_data <= ~d;
  endtask : write_reg

  task automatic read_next(output accel_byte_t d);
    d = 'x;
    @(posedge clk);
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    if (rd_valid === 1'b1) d = rd_data;
  endtask : read_next

  task automatic stop();
    @(posedge clk);
    stop_stb <= 1'b1;
    @(posedge clk);
    stop_stb <= 1'b0;
  endtask : stop
endmodule : accel_host_bfm

/* test/tb.sv */
// Self-checking bench for the upper register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import accel_pkg::*;

  localparam logic [13:0] xs1 = 14'h2a5c;
  localparam logic [13:0] xs2 = 14'h15a3;
  localparam logic [13:0] ys  = 14'h3f01;
  localparam logic [13:0] zs  = 14'h0c7e;

  logic         clk = 1'b0;
  logic         rst_b;
  logic         addr_stb, wr_stb, rd_stb, stop_stb, rd_valid;
  accel_byte_t  addr_in, wr_data, rd_data, lower_addr, lower_rdata;
  accel_fmode_t fifo_mode;
  accel_byte_t  sample_status, fifo_status, pulse_event_source_in;
  logic [13:0]  x_sample, y_sample, z_sample;
  logic         pulse_event_source_load, device_active, sw_reset;
  accel_byte_t  pulse_event_source, system_control_a;
  accel_byte_t  pulse_config, system_control_b, z_axis_trim;
  logic         lower_rd_stb;
  logic [2:0]   dbnc_restart;
  int           fails, samples_checked, cycles;

  always #2 clk = ~clk;
  // Lower bank answers only while it is strobed
  assign lower_rdata = lower_rd_stb ? (lower_addr ^ 8'h5a) : 8'h00;

  accel_host_bfm accel_host_bfm_inst (.clk(clk), .addr_stb(addr_stb),
    .addr_in(addr_in), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .stop_stb(stop_stb), .rd_valid(rd_valid),
    .rd_data(rd_data));

  accel_regmap accel_regmap_inst (.clk(clk), .rst_b(rst_b),
    .addr_stb(addr_stb), .addr_in(addr_in), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .stop_stb(stop_stb),
    .rd_valid(rd_valid), .rd_data(rd_data), .fifo_mode(fifo_mode),
    .sample_status(sample_status), .fifo_status(fifo_status),
    .x_sample(x_sample), .y_sample(y_sample), .z_sample(z_sample),
    .pulse_event_source_load(pulse_event_source_load), .pulse_event_source_in(pulse_event_source_in),
    .lower_rd_stb(lower_rd_stb), .lower_addr(lower_addr),
    .lower_rdata(lower_rdata), .pulse_config(pulse_config),
    .pulse_event_source(pulse_event_source),
    .pulse_threshold_x(), .pulse_threshold_y(), .pulse_threshold_z(),
    .pulse_time_limit(), .pulse_second_latency(),
    .pulse_second_window(), .auto_sleep_counter(),
    .system_control_a(system_control_a),
    .system_control_b(system_control_b),
    .wake_and_pin_polarity(), .interrupt_enables(),
    .interrupt_pin_routing(), .x_axis_trim(), .y_axis_trim(),
    .z_axis_trim(z_axis_trim), .device_active(device_active),
    .sw_reset(sw_reset),
    .dbnc_restart(dbnc_restart));

  function automatic accel_byte_t pat(input int a);
    return 8'(a) ^ 8'hc3;
  endfunction : pat

  task automatic check(input accel_byte_t got, input accel_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_next(input accel_byte_t exp);
    accel_byte_t d;
    accel_host_bfm_inst.read_next(d);
    check(d, exp);
  endtask : rd_next

  task automatic rd_at(input accel_byte_t a, input accel_byte_t exp);
    accel_host_bfm_inst.set_ptr(a);
    rd_next(exp);
  endtask : rd_at

  task automatic wr(input accel_byte_t a, input accel_byte_t d);
    accel_host_bfm_inst.write_reg(a, d);
    #1;
  endtask : wr

  task automatic t_reset();
    for (int a = 'h21; a <= 'h31; a++) rd_at(8'(a), 8'h00);
    check({7'h00, device_active}, 8'h00);
    $display("test reset_values done");
  endtask : t_reset

  task automatic t_standby();
    for (int a = 'h21; a <= 'h31; a++) begin
      if (a != 'h2a && a != 'h2b) begin
        wr(8'(a), pat(a));
        check(8'(dbnc_restart), (a >= 'h23 && a <= 'h25) ?
              8'(3'b001 << (a - 'h23)) : 8'h00);
      end
    end
    for (int a = 'h21; a <= 'h31; a++)
      rd_at(8'(a), (a == 'h22 || a == 'h2a || a == 'h2b) ?
            8'h00 : pat(a));
    check(z_axis_trim, pat('h31));
    $display("test standby_writes done");
  endtask : t_standby

  task automatic t_burst();
    rd_at(8'h30, pat('h30));
    rd_next(pat('h31));
    rd_next(8'h0d ^ 8'h5a);
    $display("test burst_wrap done");
  endtask : t_burst

  task automatic t_status();
    accel_host_bfm_inst.set_ptr(8'h25);
    accel_host_bfm_inst.stop();
    rd_next(sample_status);
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      fifo_mode <= accel_fmode_t'(m);
      accel_host_bfm_inst.set_ptr(8'h2f);
      accel_host_bfm_inst.stop();
      rd_next(fifo_status);
      rd_next(xs1[13:6]);
    end
    @(posedge clk);
    fifo_mode <= ACCEL_FMODE_OFF;
    $display("test status_select done");
  endtask : t_status

  task automatic t_data();
    rd_at(8'h01, xs1[13:6]);
    @(posedge clk);
    x_sample <= xs2;
    rd_next({xs1[5:0], 2'b00});
    rd_next(ys[13:6]);
    rd_next({ys[5:0], 2'b00});
    rd_next(zs[13:6]);
    rd_next({zs[5:0], 2'b00});
    rd_next(8'h07 ^ 8'h5a);
    wr(8'h2a, 8'h02);
    rd_at(8'h01, xs2[13:6]);
    rd_next(ys[13:6]);
    rd_next(zs[13:6]);
    rd_next(sample_status);
    wr(8'h2a, 8'h00);
    $display("test data_order done");
  endtask : t_data

  task automatic t_reserved();
    wr(8'h40, 8'hff);
    rd_at(8'h40, 8'h00);
    rd_at(8'h7f, 8'h00);
    rd_at(8'h32, 8'h00);
    $display("test reserved done");
  endtask : t_reserved

  task automatic t_active();
    @(posedge clk);
    pulse_event_source_load <= 1'b1;
    pulse_event_source_in   <= 8'h5c;
    @(posedge clk);
    pulse_event_source_load <= 1'b0;
    #1;
    check(pulse_event_source, 8'h5c);
    wr(8'h2a, 8'h01);
    check({7'h00, device_active}, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    check(pulse_event_source, 8'h00);
    wr(8'h21, 8'h77);
    rd_at(8'h21, pat('h21));
    check(pulse_config, pat('h21));
    wr(8'h2a, 8'h03);
    check(system_control_a, 8'h01);
    wr(8'h24, 8'h11);
    check(8'(dbnc_restart), 8'h02);
    rd_at(8'h24, 8'h11);
    wr(8'h2a, 8'h00);
    rd_at(8'h21, pat('h21));
    rd_at(8'h24, 8'h11);
    rd_at(8'h31, pat('h31));
    $display("test active_protect done");
  endtask : t_active

  task automatic t_swreset();
    wr(8'h2a, 8'h01);
    wr(8'h2b, 8'h40);
    check({7'h00, sw_reset}, 8'h01);
    check(system_control_b, 8'h40);
    repeat (2) @(posedge clk);
    for (int a = 'h21; a <= 'h31; a++) rd_at(8'(a), 8'h00);
    check({7'h00, device_active}, 8'h00);
    $display("test soft_reset done");
  endtask : t_swreset

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    {fails, samples_checked, cycles} = '0;
    rst_b          = 1'b0;
    fifo_mode      = ACCEL_FMODE_OFF;
    sample_status  = 8'h3b;
    fifo_status    = 8'hc6;
    pulse_event_source_load = 1'b0;
    pulse_event_source_in   = 8'h00;
    x_sample       = xs1;
    y_sample       = ys;
    z_sample       = zs;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_standby();
    t_burst();
    t_status();
    t_data();
    t_reserved();
    t_active();
    t_swreset();
    complete_run();
  end
endmodule : tb
